// ===== common/muldiv_defs.svh
`ifndef MULDIV_DEFS_SVH
`define MULDIV_DEFS_SVH

// Register byte offsets
`define OFF_CTRL     8'h00
`define OFF_EXEC     8'h04
`define OFF_SRC1     8'h08
`define OFF_SRC2     8'h0C
`define OFF_DST      8'h10
`define OFF_FLAGS    8'h14
`define OFF_IRQ_STAT 8'h18
`define OFF_IRQ_CLR  8'h1C
`define OFF_IRQ_EN   8'h20
`define OFF_WIN_ADDR 8'h24
`define OFF_WIN_DATA 8'h28

// Control register fields
`define CTRL_COND    0
`define CTRL_OP_MSB  2
`define CTRL_OP_LSB  1

// Operand descriptor fields
`define DESC_MSB     17

// Operand kinds
`define KIND_DIRECT   2'h0
`define KIND_INDIRECT 2'h1
`define KIND_CONST    2'h2

// Operation codes
`define OP_MUL 2'h0
`define OP_DIV 2'h1
`define OP_AND 2'h2

// Flag and event bit positions
`define FLAG_ZERO 0
`define FLAG_ERR  1
`define FLAG_BUSY 2
`define EV_DONE   0
`define EV_ERR    1

// Data memory area placement in the flat word space
`define DM_BASE   10'h200
`define PTR_LIMIT 14'h0200

`endif

// ===== common/muldiv_pkg.sv
package muldiv_pkg;

	typedef logic [9:0] addr_t;

	typedef enum logic [2:0] {
		IDLE,
		FETCH,
		WAIT_PTR,
		WAIT_OPR,
		CALC,
		WR_LO,
		WR_HI
	} step_e;

	typedef struct packed {
		logic [1:0]  kind;
		logic [15:0] value;
	} operand_s;

endpackage : muldiv_pkg

// ===== design/bcd_muldiv_andword_unit.sv
// Behaviour
// - condition bit 0: nothing executes, no result or flag changes.
// - multiply two 4-digit BCD words; low digits first, high next.
// - multiply sets zero flag when whole 8-digit product is zero.
// - multiply checks both operands are BCD; else error, no write.
// - divide first by second; quotient first channel, remainder next.
// - divide sets zero flag when quotient is zero.
// - divide checks both operands are BCD; else error, no write.
// - indirect only into data memory; bad pointer gives error.
// - AND word stores bitwise AND of two 16-bit words.
// - AND word sets zero flag when result is zero.
// - AND word takes any hex constant; BCD ops only up to 9999.
// - indirect pointer's decimal value addresses data memory.
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "muldiv_defs.svh"

module bcd_muldiv_andword_unit #(
	parameter int MEM_WORDS = 1024
) (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	output logic             zero_flag,
	output logic             error_flag,
	output logic             busy
);

	function automatic logic [13:0] bcd2bin(input logic [15:0] w);
		return 14'(w[15:12]) * 14'h3E8 + 14'(w[11:8]) * 14'h064
			+ 14'(w[7:4]) * 14'h00A + 14'(w[3:0]);
	endfunction : bcd2bin

	function automatic logic is_bcd(input logic [15:0] w);
		return w[15:12] < 4'hA && w[11:8] < 4'hA && w[7:4] < 4'hA
			&& w[3:0] < 4'hA;
	endfunction : is_bcd

	function automatic logic [31:0] bin2bcd(input logic [26:0] n);
		logic [31:0] d;
		d = '0;
		for (int i = 26; i >= 0; i--) begin
			for (int k = 0; k < 8; k++) begin
				if (d[k*4 +: 4] > 4'h4)
					d[k*4 +: 4] = d[k*4 +: 4] + 4'h3;
			end
			d = {d[30:0], n[i]};
		end
		return d;
	endfunction : bin2bcd

	logic [15:0]          mem [0:MEM_WORDS-1];
	logic [15:0]          mem_q;
	muldiv_pkg::addr_t    mem_a;
	logic                 mem_we;
	logic [15:0]          mem_wd;

	logic                 cond, next_cond;
	logic [1:0]           op, next_op;
	muldiv_pkg::operand_s src1, next_src1;
	muldiv_pkg::operand_s src2, next_src2;
	muldiv_pkg::operand_s dst, next_dst;
	muldiv_pkg::operand_s cur;
	logic [1:0]           irq_stat, next_irq_stat;
	logic [1:0]           irq_en, next_irq_en;
	logic [1:0]           clr, ev;
	muldiv_pkg::addr_t    win_addr, next_win_addr;
	logic [31:0]          next_prdata;
	logic                 next_pready, next_pslverr, next_irq;
	logic                 next_zero, next_error, port_idle;
	muldiv_pkg::step_e    state, next_state;
	logic [1:0]           idx, next_idx;
	logic [15:0]          opa, next_opa, opb, next_opb;
	logic [15:0]          res_lo, next_res_lo, res_hi, next_res_hi;
	muldiv_pkg::addr_t    wptr, next_wptr;
	muldiv_pkg::addr_t    ptr_addr;
	logic                 ptr_ok;

	logic                 access, wr, mem_sel, exec_sel, stall;
	logic [13:0]          a_bin, b_bin, div_b;
	logic [26:0]          prod;
	logic [31:0]          prod_bcd;
	logic [15:0]          quot_bcd, rem_bcd;
	logic [31:0]          quot_full, rem_full;

	assign access   = psel & penable;
	assign wr       = access & pready & pwrite;
	assign mem_sel  = paddr == `OFF_WIN_DATA;
	assign exec_sel = paddr == `OFF_EXEC;
	assign stall    = (mem_sel | (exec_sel & pwrite))
		& !(state == muldiv_pkg::IDLE & port_idle);

	assign a_bin    = bcd2bin(opa);
	assign b_bin    = bcd2bin(opb);
	assign div_b    = (b_bin == 14'h0000) ? 14'h0001 : b_bin;
	assign prod     = 27'(a_bin) * 27'(b_bin);
	assign prod_bcd = bin2bcd(prod);
	// Quotient and remainder never exceed four digits
	assign quot_full = bin2bcd(27'(a_bin / div_b));
	assign rem_full  = bin2bcd(27'(a_bin % div_b));
	assign quot_bcd  = quot_full[15:0];
	assign rem_bcd   = rem_full[15:0];

	// pointer decimal value into data memory
	assign ptr_ok   = is_bcd(mem_q) && bcd2bin(mem_q) < `PTR_LIMIT;
	assign ptr_addr = `DM_BASE + muldiv_pkg::addr_t'(bcd2bin(mem_q));

	// Register file and bus answers
	always_comb begin
		next_cond     = cond;
		next_op       = op;
		next_src1     = src1;
		next_src2     = src2;
		next_dst      = dst;
		next_irq_en   = irq_en;
		next_win_addr = win_addr;
		clr           = 2'h0;
		if (wr) begin
			if (paddr == `OFF_CTRL) begin
				next_cond = pwdata[`CTRL_COND];
				next_op   = pwdata[`CTRL_OP_MSB:`CTRL_OP_LSB];
			end else if (paddr == `OFF_SRC1) begin
				next_src1 = pwdata[`DESC_MSB:0];
			end else if (paddr == `OFF_SRC2) begin
				next_src2 = pwdata[`DESC_MSB:0];
			end else if (paddr == `OFF_DST) begin
				next_dst = pwdata[`DESC_MSB:0];
			end else if (paddr == `OFF_IRQ_CLR) begin
				clr = pwdata[1:0];
			end else if (paddr == `OFF_IRQ_EN) begin
				next_irq_en = pwdata[1:0];
			end else if (paddr == `OFF_WIN_ADDR) begin
				next_win_addr = pwdata[9:0];
			end
		end
		next_irq_stat = (irq_stat & ~clr) | ev;
		next_irq      = |(next_irq_stat & next_irq_en);
		next_pready   = access & !pready & !stall;
		next_pslverr  = 1'b0;
		next_prdata   = 32'h0000_0000;
		if (next_pready) begin
			if (paddr == `OFF_CTRL)
				next_prdata = 32'({op, cond});
			else if (paddr == `OFF_SRC1)
				next_prdata = 32'(src1);
			else if (paddr == `OFF_SRC2)
				next_prdata = 32'(src2);
			else if (paddr == `OFF_DST)
				next_prdata = 32'(dst);
			else if (paddr == `OFF_FLAGS)
				next_prdata = 32'({busy, error_flag, zero_flag});
			else if (paddr == `OFF_IRQ_STAT)
				next_prdata = 32'(irq_stat);
			else if (paddr == `OFF_IRQ_EN)
				next_prdata = 32'(irq_en);
			else if (paddr == `OFF_WIN_ADDR)
				next_prdata = 32'(win_addr);
			else if (mem_sel)
				next_prdata = 32'(mem_q);
			else if (!exec_sel && paddr != `OFF_IRQ_CLR)
				next_pslverr = 1'b1;
			if (pwrite)
				next_prdata = 32'h0000_0000;
		end
	end

	// Execution sequencer
	always_comb begin
		next_state  = state;
		next_idx    = idx;
		next_opa    = opa;
		next_opb    = opb;
		next_res_lo = res_lo;
		next_res_hi = res_hi;
		next_wptr   = wptr;
		next_zero   = zero_flag;
		next_error  = error_flag;
		ev          = 2'h0;
		mem_a       = win_addr;
		mem_we      = wr & mem_sel;
		mem_wd      = pwdata[15:0];
		cur         = (idx == 2'h0) ? src1 : (idx == 2'h1) ? src2 : dst;
		case (state)
			muldiv_pkg::IDLE: begin
				if (wr && exec_sel && cond) begin
					next_state = muldiv_pkg::FETCH;
					next_idx   = 2'h0;
				end
			end
			muldiv_pkg::FETCH: begin
				mem_a = cur.value[9:0];
				if (cur.kind == `KIND_CONST && idx != 2'h2) begin
					if (idx == 2'h0)
						next_opa = cur.value;
					else
						next_opb = cur.value;
					next_idx = idx + 2'h1;
				end else if (cur.kind == `KIND_DIRECT) begin
					if (idx == 2'h2) begin
						next_wptr  = cur.value[9:0];
						next_state = muldiv_pkg::CALC;
					end else begin
						next_state = muldiv_pkg::WAIT_OPR;
					end
				end else if (cur.kind == `KIND_INDIRECT) begin
					next_state = muldiv_pkg::WAIT_PTR;
				end else begin
					next_error = 1'b1;
					ev[`EV_ERR] = 1'b1;
					next_state = muldiv_pkg::IDLE;
				end
			end
			muldiv_pkg::WAIT_PTR: begin
				mem_a = ptr_addr;
				if (!ptr_ok) begin
					next_error = 1'b1;
					ev[`EV_ERR] = 1'b1;
					next_state = muldiv_pkg::IDLE;
				end else if (idx == 2'h2) begin
					next_wptr  = ptr_addr;
					next_state = muldiv_pkg::CALC;
				end else begin
					next_state = muldiv_pkg::WAIT_OPR;
				end
			end
			muldiv_pkg::WAIT_OPR: begin
				if (idx == 2'h0)
					next_opa = mem_q;
				else
					next_opb = mem_q;
				next_idx   = idx + 2'h1;
				next_state = muldiv_pkg::FETCH;
			end
			muldiv_pkg::CALC: begin
				next_state = muldiv_pkg::WR_LO;
				next_error = 1'b0;
				if ((op != `OP_AND && !(is_bcd(opa) && is_bcd(opb)))
					|| op > `OP_AND
					|| (op == `OP_DIV && b_bin == 14'h0000)) begin
					next_error = 1'b1;
					ev[`EV_ERR] = 1'b1;
					next_state = muldiv_pkg::IDLE;
				end else if (op == `OP_MUL) begin
					next_res_lo = prod_bcd[15:0];
					next_res_hi = prod_bcd[31:16];
					next_zero   = prod_bcd == 32'h0000_0000;
				end else if (op == `OP_DIV) begin
					next_res_lo = quot_bcd;
					next_res_hi = rem_bcd;
					next_zero   = quot_bcd == 16'h0000;
				end else begin
					next_res_lo = opa & opb;
					next_zero   = (opa & opb) == 16'h0000;
				end
			end
			muldiv_pkg::WR_LO: begin
				mem_a  = wptr;
				mem_we = 1'b1;
				mem_wd = res_lo;
				if (op == `OP_AND) begin
					ev[`EV_DONE] = 1'b1;
					next_state = muldiv_pkg::IDLE;
				end else begin
					next_state = muldiv_pkg::WR_HI;
				end
			end
			muldiv_pkg::WR_HI: begin
				mem_a  = wptr + 10'h001;
				mem_we = 1'b1;
				mem_wd = res_hi;
				ev[`EV_DONE] = 1'b1;
				next_state = muldiv_pkg::IDLE;
			end
			default: next_state = muldiv_pkg::IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (mem_we)
			mem[mem_a] <= mem_wd;
		mem_q <= mem[mem_a];
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cond       <= 1'b0;
			op         <= `OP_MUL;
			src1       <= '0;
			src2       <= '0;
			dst        <= '0;
			irq_stat   <= 2'h0;
			irq_en     <= 2'h0;
			win_addr   <= '0;
			prdata     <= 32'h0000_0000;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			irq        <= 1'b0;
			zero_flag  <= 1'b0;
			error_flag <= 1'b0;
			busy       <= 1'b0;
			port_idle  <= 1'b0;
			state      <= muldiv_pkg::IDLE;
			idx        <= 2'h0;
			opa        <= 16'h0000;
			opb        <= 16'h0000;
			res_lo     <= 16'h0000;
			res_hi     <= 16'h0000;
			wptr       <= '0;
		end else begin
			cond       <= next_cond;
			op         <= next_op;
			src1       <= next_src1;
			src2       <= next_src2;
			dst        <= next_dst;
			irq_stat   <= next_irq_stat;
			irq_en     <= next_irq_en;
			win_addr   <= next_win_addr;
			prdata     <= next_prdata;
			pready     <= next_pready;
			pslverr    <= next_pslverr;
			irq        <= next_irq;
			zero_flag  <= next_zero;
			error_flag <= next_error;
			busy       <= next_state != muldiv_pkg::IDLE;
			port_idle  <= state == muldiv_pkg::IDLE;
			state      <= next_state;
			idx        <= next_idx;
			opa        <= next_opa;
			opb        <= next_opb;
			res_lo     <= next_res_lo;
			res_hi     <= next_res_hi;
			wptr       <= next_wptr;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence calc_ok;
		state == muldiv_pkg::CALC && next_state == muldiv_pkg::WR_LO;
	endsequence

	cond_low_idle_a: assert property (
		(state == muldiv_pkg::IDLE && wr && exec_sel && !cond)
		|=> state == muldiv_pkg::IDLE && $stable(zero_flag)
		&& $stable(error_flag))
		else $error("Ran with condition bit clear");
	hi_word_next_a: assert property (
		(state == muldiv_pkg::WR_LO && op != `OP_AND) |=>
		state == muldiv_pkg::WR_HI && mem_we && mem_a == wptr + 10'h001
		&& mem_wd == res_hi)
		else $error("High word not written to next channel");
	mul_zero_a: assert property (
		(calc_ok and op == `OP_MUL) |=>
		zero_flag == (res_lo == 16'h0000 && res_hi == 16'h0000))
		else $error("Product zero flag wrong");
	bcd_reject_a: assert property (
		(state == muldiv_pkg::CALC && op != `OP_AND && !is_bcd(opa))
		|=> error_flag && state == muldiv_pkg::IDLE ##1 !mem_we)
		else $error("Non-BCD operand not refused");
	div_result_a: assert property (
		(calc_ok and op == `OP_DIV) |=>
		bcd2bin(res_lo) * $past(b_bin) + bcd2bin(res_hi) == $past(a_bin)
		&& bcd2bin(res_hi) < $past(b_bin))
		else $error("Quotient or remainder wrong");
	ptr_reject_a: assert property (
		(state == muldiv_pkg::WAIT_PTR && !ptr_ok) |=>
		error_flag && state == muldiv_pkg::IDLE && irq_stat[`EV_ERR])
		else $error("Bad pointer not refused");
	and_result_a: assert property (
		(calc_ok and op == `OP_AND) |=>
		res_lo == ($past(opa) & $past(opb)) && mem_we && mem_a == wptr
		&& mem_wd == res_lo)
		else $error("AND word result wrong");
	nonzero_clear_a: assert property (
		(state == muldiv_pkg::WR_LO && res_lo != 16'h0000) |-> !zero_flag)
		else $error("Zero flag set on nonzero result");

endmodule : bcd_muldiv_andword_unit

`default_nettype wire

// ===== tb/scan_sequencer_model.sv
`timescale 1ns/1ps
`default_nettype none

module scan_sequencer_model (
	input  wire logic        core_clk,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	output var  logic        psel,
	output var  logic        penable,
	output var  logic        pwrite,
	output var  logic [7:0]  paddr,
	output var  logic [31:0] pwdata
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end

	// Address and data are scrambled once the request is released
	task automatic xfer(input logic w, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] q,
			output logic e);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer

endmodule : scan_sequencer_model

`default_nettype wire

// ===== tb/bcd_muldiv_andword_unit_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "muldiv_defs.svh"

module bcd_muldiv_andword_unit_test;
	logic        core_clk;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic        zero_flag;
	logic        error_flag;
	logic        busy;
	int          n_mismatch;
	int          compares;

	bcd_muldiv_andword_unit dut_u (
		.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq),
		.zero_flag(zero_flag), .error_flag(error_flag), .busy(busy)
	);

	scan_sequencer_model seq_u (
		.core_clk(core_clk), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata)
	);

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	function automatic logic [31:0] bcd(input int v);
		logic [31:0] r;
		r = 32'h0;
		for (int i = 0; i < 8; i++) begin
			r[4*i+:4] = 4'(v % 10);
			v = v / 10;
		end
		return r;
	endfunction : bcd

	function automatic int dec(input logic [15:0] b);
		return b[15:12] * 1000 + b[11:8] * 100 + b[7:4] * 10 + b[3:0];
	endfunction : dec

	task automatic chk(input string nm, input logic [31:0] exp,
			input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		seq_u.xfer(1'b1, a, d, q, e);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		logic e;
		seq_u.xfer(1'b0, a, 32'h0, q, e);
	endtask : rd

	task automatic put(input logic [9:0] a, input logic [15:0] d);
		wr(`OFF_WIN_ADDR, {22'h0, a});
		wr(`OFF_WIN_DATA, {16'h0, d});
	endtask : put

	task automatic peek(input string nm, input logic [9:0] a,
			input logic [15:0] exp);
		logic [31:0] q;
		wr(`OFF_WIN_ADDR, {22'h0, a});
		rd(`OFF_WIN_DATA, q);
		chk(nm, {16'h0, exp}, q);
	endtask : peek

	task automatic run(input logic [2:0] c, input logic [17:0] s1, s2, dst);
		wr(`OFF_CTRL, {29'h0, c});
		wr(`OFF_SRC1, {14'h0, s1});
		wr(`OFF_SRC2, {14'h0, s2});
		wr(`OFF_DST, {14'h0, dst});
		wr(`OFF_EXEC, 32'h1);
		repeat (2) @(posedge core_clk);
		while (busy !== 1'b0)
			@(posedge core_clk);
		repeat (2) @(posedge core_clk);
	endtask : run

	task automatic arith(input logic [1:0] op, input logic [15:0] a, b);
		logic [31:0] q;
		logic [31:0] r;
		logic        z;
		put(10'h040, b);
		put(10'h3FF, 16'hA5A5);
		run({op, 1'b1}, {2'h2, a}, 18'h0_0040, 18'h0_03FE);
		if (op == 2'h0) begin
			q = bcd(dec(a) * dec(b));
			z = (q == 32'h0);
		end else if (op == `OP_DIV) begin
			q = bcd(dec(a) / dec(b));
			r = bcd(dec(a) % dec(b));
			z = (q[15:0] == 16'h0);
			q = {r[15:0], q[15:0]};
		end else begin
			q = {16'hA5A5, a & b};
			z = ((a & b) == 16'h0);
		end
		peek("result lo", 10'h3FE, q[15:0]);
		peek("result hi", 10'h3FF, q[31:16]);
		chk("flags", {30'h0, 1'b0, z}, {30'h0, error_flag, zero_flag});
	endtask : arith

	task automatic bad(input logic [2:0] c, input logic [17:0] s1, s2);
		logic z;
		put(10'h3FE, 16'hA5A5);
		put(10'h3FF, 16'hA5A5);
		z = zero_flag;
		run(c, s1, s2, 18'h0_03FE);
		chk("error flags", {30'h0, 1'b1, z}, {30'h0, error_flag, zero_flag});
		peek("kept lo", 10'h3FE, 16'hA5A5);
		peek("kept hi", 10'h3FF, 16'hA5A5);
	endtask : bad

	task automatic t_bcd();
		arith(2'h0, 16'h1234, 16'h5678);
		arith(2'h0, 16'h0000, 16'h4321);
		arith(2'h0, 16'h9999, 16'h9999);
		arith(`OP_DIV, 16'h9999, 16'h0007);
		arith(`OP_AND, 16'hF0A5, 16'h9B3C);
		arith(`OP_AND, 16'h0F0F, 16'hF0F0);
		arith(`OP_DIV, 16'h0003, 16'h0007);
	endtask : t_bcd

	task automatic t_err();
		put(10'h040, 16'h00F0);
		put(10'h072, 16'h0512);
		bad({2'h0, 1'b1}, 18'h2_12A4, 18'h2_0001);
		bad({`OP_DIV, 1'b1}, 18'h2_0010, 18'h0_0040);
		bad({2'h0, 1'b1}, 18'h2_A000, 18'h2_0002);
		bad({`OP_AND, 1'b1}, 18'h1_0072, 18'h2_FFFF);
		bad({`OP_DIV, 1'b1}, 18'h2_0010, 18'h2_0000);
	endtask : t_err

	task automatic t_ind();
		put(10'h070, 16'h0200);
		put(10'h071, 16'h0510);
		put(10'h2C8, 16'h0025);
		run({`OP_AND, 1'b1}, 18'h1_0070, 18'h2_FFFF, 18'h1_0071);
		peek("indirect", 10'h3FE, 16'h0025);
	endtask : t_ind

	task automatic t_irq();
		logic [31:0] q;
		logic        e;
		logic [1:0]  f;
		wr(`OFF_IRQ_CLR, 32'h3);
		put(10'h3FE, 16'hA5A5);
		f = {error_flag, zero_flag};
		run({`OP_AND, 1'b0}, 18'h2_0000, 18'h2_0000, 18'h0_03FE);
		chk("idle flags", {30'h0, f}, {30'h0, error_flag, zero_flag});
		peek("idle dst", 10'h3FE, 16'hA5A5);
		rd(`OFF_IRQ_STAT, q);
		chk("idle stat", 32'h0, q);
		run({`OP_AND, 1'b1}, 18'h2_0001, 18'h2_0003, 18'h0_03FE);
		rd(`OFF_IRQ_STAT, q);
		chk("done stat", 32'h1, q);
		rd(`OFF_FLAGS, q);
		chk("flag reg", 32'h0, q);
		chk("masked irq", 32'h0, {31'h0, irq});
		wr(`OFF_IRQ_EN, 32'h1);
		repeat (2) @(posedge core_clk);
		chk("irq on", 32'h1, {31'h0, irq});
		wr(`OFF_IRQ_CLR, 32'h1);
		repeat (2) @(posedge core_clk);
		chk("irq off", 32'h0, {31'h0, irq});
		seq_u.xfer(1'b0, 8'h3C, 32'h0, q, e);
		chk("unmapped", 32'h1, {31'h0, e});
	endtask : t_irq

	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	initial begin
		rst = 1'b1;
		n_mismatch = 0;
		compares = 0;
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		chk("reset pins", 32'h0, {28'h0, irq, zero_flag, error_flag, busy});
		t_bcd();
		t_err();
		t_ind();
		t_irq();
		print_verdict();
	end

	initial begin
		#100us;
		n_mismatch++;
		print_verdict();
	end

endmodule : bcd_muldiv_andword_unit_test

`default_nettype wire
